// ===== core/conv_init_defs.svh
// Constants of the converter startup block: register offsets, field positions, reset values, timing.
// Assumes a 100 MHz ref_clk and an 8-bit byte address on the register port.
`ifndef CONV_INIT_DEFS_SVH
`define CONV_INIT_DEFS_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_CTRL       8'h00
`define ADDR_PLL_CFG    8'h04
`define ADDR_TRIM       8'h08
`define ADDR_LINK_CFG   8'h0c
`define ADDR_STATUS     8'h10
`define ADDR_IRQ_STAT   8'h14
`define ADDR_IRQ_MASK   8'h18
`define ADDR_CAL_CFG    8'h1c
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_SOFT_RESET   0
`define CTRL_PLL_RESET    1
`define CTRL_LINK_EN      2
`define CTRL_CAL_EN       3
`define CTRL_OVER_RANGE_ENABLE       4
`define CTRL_SOFT_TRIG    5
`define CTRL_PIN_TRIG_EN  6
`define CTRL_CAL_STAT_SEL 7
`define CTRL_OSC_CAL_EN   8
`define LINK_MODE_HI      4
`define LINK_KM1_LO       8
`define LINK_KM1_HI       12
`define LINK_SYNC_SEL     16
`define CAL_CFG_BG_MODE   0
`define IRQ_INIT          0
`define IRQ_LOCK          1
`define IRQ_FOREGROUND_DONE_FLAG       2
`define IRQ_VALID         3
// ----------------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------------
`define CTRL_MASK      32'h0000_01fe
`define CTRL_RESET     32'h0000_000c
`define PLL_CFG_RESET  32'h0000_0000
`define TRIM_MASK      32'h0000_00ff
`define LINK_CFG_MASK  32'hff01_1f1f
`define LINK_CFG_RESET 32'h0000_0000
`define CAL_CFG_MASK   32'h0000_0003
`define IRQ_MASK_BITS  32'h0000_000f
`define WORD_ZERO      32'h0000_0000
`define LINK_MODE_64B_FIRST 5'h08
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define INIT_TIME_NS    2000
`define OSC_CAL_TIME_NS 5000
`define LOCK_TIME_NS    1000
`define FG_CAL_TIME_NS  20000
`define INIT_CYCLES    ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_CAL_CYCLES ((`OSC_CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_CYCLES    ((`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FG_CAL_CYCLES  ((`FG_CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== core/conv_init_pkg.sv
// Types shared by the converter startup block.
// Assumes nothing of its surroundings.
package conv_init_pkg;
  typedef enum logic [1:0] {PLL_HELD, PLL_OSC_CAL, PLL_LOCKING, PLL_LOCKED} pll_state_type;
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} cal_state_type;
  typedef enum logic [1:0] {LINK_HALT, LINK_WAIT_SYNC, LINK_RUN} link_state_type;
endpackage

// ===== core/converter_startup_init_sequence.sv
// Startup, PLL, calibration and link control of the converter, seen from its register port.
// Assumes one 100 MHz clock; pins and receiver status arrive asynchronously and are synchronised here.
//
// Notes on behaviour
// - After soft reset, device sets init-done; host waits for it.
// - Releasing PLL reset starts oscillator calibration or uses trim, then locks.
// - Link enable 0 halts the link; link settings change only while halted.
// - Calibration enable 0 halts calibration; its settings change only while halted.
// - Enabling calibration then link restarts the link state machine.
// - Finished foreground calibration raises the status pin and the done flag.
// - In 8B/10B modes the link follows receiver sync; 64B/66B ignores it.
// - Data is valid only with receiver alignment and calibration finished.
//
// The implementer's own choices: the address map and strobed register access.
`include "conv_init_defs.svh"

module converter_startup_init_sequence (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  input  wire logic        pll_enable_strap,
  input  wire logic        single_ended_sync_input,
  input  wire logic        timestamp_diff_input,
  input  wire logic        calibration_trigger_pin,
  input  wire logic        rx_aligned,
  output logic             calibration_status_pin,
  output logic             link_active,
  output logic             data_valid,
  output logic             irq
);
  localparam int INIT_CYC = `INIT_CYCLES;
  localparam int INIT_MAX = `INIT_CYCLES + 2;
  localparam int FG_CYC   = `FG_CAL_CYCLES;

  function automatic logic is_8b10b(input logic [4:0] mode);
    is_8b10b = mode < `LINK_MODE_64B_FIRST;
  endfunction

  // ----------------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------------
  logic [1:0] strap_sync_ff;
  logic [1:0] se_sync_ff;
  logic [1:0] ts_sync_ff;
  logic [1:0] trig_sync_ff;
  logic [1:0] align_sync_ff;
  logic       trig_prev_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_sync_ff <= 2'h0;
      se_sync_ff    <= 2'h0;
      ts_sync_ff    <= 2'h0;
      trig_sync_ff  <= 2'h0;
      align_sync_ff <= 2'h0;
      trig_prev_ff  <= 1'h0;
    end else begin
      strap_sync_ff <= {strap_sync_ff[0], pll_enable_strap};
      se_sync_ff    <= {se_sync_ff[0], single_ended_sync_input};
      ts_sync_ff    <= {ts_sync_ff[0], timestamp_diff_input};
      trig_sync_ff  <= {trig_sync_ff[0], calibration_trigger_pin};
      align_sync_ff <= {align_sync_ff[0], rx_aligned};
      trig_prev_ff  <= trig_sync_ff[1];
    end
  end

  // ----------------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------------
  logic [31:0] ctrl_ff, pll_cfg_ff, trim_ff, link_cfg_ff, cal_cfg_ff, irq_stat_ff, irq_mask_ff, rd_data_ff;
  logic [31:0] nxt_ctrl, nxt_pll_cfg, nxt_trim, nxt_link_cfg, nxt_cal_cfg, nxt_irq_stat, nxt_irq_mask;
  logic [31:0] nxt_rd_data, status_word;
  logic        irq_ff, nxt_irq, link_cfg_open, cal_cfg_open;
  logic [3:0]  events;
  logic        init_done_ff, nxt_init_done, osc_cal_done_ff, nxt_osc_cal_done;
  logic        pll_locked_ff, nxt_pll_locked, foreground_done_flag_ff, nxt_foreground_done_flag;
  logic        data_valid_ff, nxt_data_valid, link_active_ff, nxt_link_active;
  conv_init_pkg::cal_state_type  cal_state_ff, nxt_cal_state;
  conv_init_pkg::link_state_type link_state_ff, nxt_link_state;

  // Settings that steer a running machine are frozen, so a mid-flight write cannot corrupt it.
  assign link_cfg_open = !ctrl_ff[`CTRL_LINK_EN] && (link_state_ff == conv_init_pkg::LINK_HALT);
  assign cal_cfg_open  = !ctrl_ff[`CTRL_CAL_EN] && (cal_state_ff == conv_init_pkg::CAL_IDLE);
  assign status_word = {25'h0, data_valid_ff, cal_state_ff == conv_init_pkg::CAL_RUN, link_active_ff,
                        foreground_done_flag_ff, pll_locked_ff, osc_cal_done_ff, init_done_ff};
  assign events = {nxt_data_valid & ~data_valid_ff, nxt_foreground_done_flag & ~foreground_done_flag_ff,
                   nxt_pll_locked & ~pll_locked_ff, nxt_init_done & ~init_done_ff};

  always_comb begin
    nxt_ctrl                   = ctrl_ff;
    nxt_ctrl[`CTRL_SOFT_RESET] = 1'b0;
    nxt_pll_cfg                = pll_cfg_ff;
    nxt_trim                   = trim_ff;
    nxt_link_cfg               = link_cfg_ff;
    nxt_cal_cfg                = cal_cfg_ff;
    nxt_irq_mask               = irq_mask_ff;
    nxt_irq_stat               = irq_stat_ff;
    nxt_rd_data                = `WORD_ZERO;
    if (wr_en) begin
      if (addr == `ADDR_CTRL) begin
        nxt_ctrl = wr_data & (`CTRL_MASK | 32'h0000_0001);
      end else if (addr == `ADDR_PLL_CFG) begin
        nxt_pll_cfg = wr_data;
      end else if (addr == `ADDR_TRIM) begin
        nxt_trim = wr_data & `TRIM_MASK;
      end else if (addr == `ADDR_LINK_CFG && link_cfg_open) begin
        nxt_link_cfg = wr_data & `LINK_CFG_MASK;
      end else if (addr == `ADDR_CAL_CFG && cal_cfg_open) begin
        nxt_cal_cfg = wr_data & `CAL_CFG_MASK;
      end else if (addr == `ADDR_IRQ_MASK) begin
        nxt_irq_mask = wr_data & `IRQ_MASK_BITS;
      end
    end
    if (rd_en) begin
      if (addr == `ADDR_CTRL) begin
        nxt_rd_data = ctrl_ff;
      end else if (addr == `ADDR_PLL_CFG) begin
        nxt_rd_data = pll_cfg_ff;
      end else if (addr == `ADDR_TRIM) begin
        nxt_rd_data = trim_ff;
      end else if (addr == `ADDR_LINK_CFG) begin
        nxt_rd_data = link_cfg_ff;
      end else if (addr == `ADDR_STATUS) begin
        nxt_rd_data = status_word;
      end else if (addr == `ADDR_IRQ_STAT) begin
        nxt_rd_data  = irq_stat_ff;
        nxt_irq_stat = `WORD_ZERO;
      end else if (addr == `ADDR_IRQ_MASK) begin
        nxt_rd_data = irq_mask_ff;
      end else if (addr == `ADDR_CAL_CFG) begin
        nxt_rd_data = cal_cfg_ff;
      end
    end
    // An event in the clearing cycle survives: the set is applied after the clear.
    nxt_irq_stat = nxt_irq_stat | {28'h0, events};
    nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_ff     <= `CTRL_RESET;
      pll_cfg_ff  <= `PLL_CFG_RESET;
      trim_ff     <= `WORD_ZERO;
      link_cfg_ff <= `LINK_CFG_RESET;
      cal_cfg_ff  <= `WORD_ZERO;
      irq_stat_ff <= `WORD_ZERO;
      irq_mask_ff <= `WORD_ZERO;
      rd_data_ff  <= `WORD_ZERO;
      irq_ff      <= 1'b0;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      pll_cfg_ff  <= nxt_pll_cfg;
      trim_ff     <= nxt_trim;
      link_cfg_ff <= nxt_link_cfg;
      cal_cfg_ff  <= nxt_cal_cfg;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      rd_data_ff  <= nxt_rd_data;
      irq_ff      <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------------------
  // Initialisation and converter PLL
  // ----------------------------------------------------------------------------
  logic [11:0] init_cnt_ff, nxt_init_cnt, pll_cnt_ff, nxt_pll_cnt;
  logic        pll_rst_prev_ff;
  conv_init_pkg::pll_state_type pll_state_ff, nxt_pll_state;

  always_comb begin
    nxt_init_cnt     = init_cnt_ff;
    nxt_init_done    = init_done_ff;
    nxt_pll_state    = pll_state_ff;
    nxt_pll_cnt      = pll_cnt_ff + 12'h001;
    nxt_osc_cal_done = osc_cal_done_ff;
    nxt_pll_locked   = pll_locked_ff;
    if (ctrl_ff[`CTRL_SOFT_RESET]) begin
      nxt_init_cnt  = 12'h000;
      nxt_init_done = 1'b0;
    end else if (!init_done_ff) begin
      nxt_init_cnt = init_cnt_ff + 12'h001;
      if (init_cnt_ff == 12'(`INIT_CYCLES - 1)) nxt_init_done = 1'b1;
    end
    case (pll_state_ff)
      conv_init_pkg::PLL_HELD: begin
        // The release edge of the PLL reset starts the bring-up; a manual trim skips calibration.
        if (pll_rst_prev_ff && !ctrl_ff[`CTRL_PLL_RESET] && init_done_ff) begin
          nxt_pll_cnt = 12'h000;
          if (ctrl_ff[`CTRL_OSC_CAL_EN]) begin
            nxt_pll_state = conv_init_pkg::PLL_OSC_CAL;
          end else begin
            nxt_osc_cal_done = 1'b1;
            nxt_pll_state    = conv_init_pkg::PLL_LOCKING;
          end
        end
      end
      conv_init_pkg::PLL_OSC_CAL: begin
        if (pll_cnt_ff == 12'(`OSC_CAL_CYCLES - 1)) begin
          nxt_osc_cal_done = 1'b1;
          nxt_pll_cnt      = 12'h000;
          nxt_pll_state    = conv_init_pkg::PLL_LOCKING;
        end
      end
      conv_init_pkg::PLL_LOCKING: begin
        if (pll_cnt_ff == 12'(`LOCK_CYCLES - 1)) begin
          nxt_pll_locked = 1'b1;
          nxt_pll_state  = conv_init_pkg::PLL_LOCKED;
        end
      end
      default: nxt_pll_cnt = pll_cnt_ff;
    endcase
    if (ctrl_ff[`CTRL_PLL_RESET] || !strap_sync_ff[1] || ctrl_ff[`CTRL_SOFT_RESET]) begin
      nxt_pll_state    = conv_init_pkg::PLL_HELD;
      nxt_osc_cal_done = 1'b0;
      nxt_pll_locked   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      init_cnt_ff     <= 12'h000;
      init_done_ff    <= 1'b0;
      pll_state_ff    <= conv_init_pkg::PLL_HELD;
      pll_cnt_ff      <= 12'h000;
      osc_cal_done_ff <= 1'b0;
      pll_locked_ff   <= 1'b0;
      pll_rst_prev_ff <= 1'b0;
    end else begin
      init_cnt_ff     <= nxt_init_cnt;
      init_done_ff    <= nxt_init_done;
      pll_state_ff    <= nxt_pll_state;
      pll_cnt_ff      <= nxt_pll_cnt;
      osc_cal_done_ff <= nxt_osc_cal_done;
      pll_locked_ff   <= nxt_pll_locked;
      pll_rst_prev_ff <= ctrl_ff[`CTRL_PLL_RESET];
    end
  end

  // ----------------------------------------------------------------------------
  // Foreground calibration
  // ----------------------------------------------------------------------------
  logic [11:0] cal_cnt_ff, nxt_cal_cnt;
  logic        soft_trig_prev_ff, cal_trigger;

  assign cal_trigger = ctrl_ff[`CTRL_CAL_EN] && !cal_cfg_ff[`CAL_CFG_BG_MODE] && init_done_ff &&
                       ((ctrl_ff[`CTRL_SOFT_TRIG] && !soft_trig_prev_ff) ||
                        (ctrl_ff[`CTRL_PIN_TRIG_EN] && trig_sync_ff[1] && !trig_prev_ff));

  always_comb begin
    nxt_cal_state = cal_state_ff;
    nxt_cal_cnt   = cal_cnt_ff;
    nxt_foreground_done_flag   = foreground_done_flag_ff;
    case (cal_state_ff)
      conv_init_pkg::CAL_RUN: begin
        nxt_cal_cnt = cal_cnt_ff + 12'h001;
        if (cal_cnt_ff == 12'(`FG_CAL_CYCLES - 1)) begin
          nxt_cal_state = conv_init_pkg::CAL_DONE;
          nxt_foreground_done_flag   = 1'b1;
        end
      end
      default: begin
        if (cal_trigger) begin
          nxt_cal_state = conv_init_pkg::CAL_RUN;
          nxt_cal_cnt   = 12'h000;
          nxt_foreground_done_flag   = 1'b0;
        end
      end
    endcase
    if (!ctrl_ff[`CTRL_CAL_EN]) begin
      nxt_cal_state = conv_init_pkg::CAL_IDLE;
      nxt_foreground_done_flag   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cal_state_ff      <= conv_init_pkg::CAL_IDLE;
      cal_cnt_ff        <= 12'h000;
      foreground_done_flag_ff        <= 1'b0;
      soft_trig_prev_ff <= 1'b0;
    end else begin
      cal_state_ff      <= nxt_cal_state;
      cal_cnt_ff        <= nxt_cal_cnt;
      foreground_done_flag_ff        <= nxt_foreground_done_flag;
      soft_trig_prev_ff <= ctrl_ff[`CTRL_SOFT_TRIG];
    end
  end

  // ----------------------------------------------------------------------------
  // Serial link control and data valid
  // ----------------------------------------------------------------------------
  logic sync_ok, mode_8b10b, cal_finished;

  assign sync_ok      = link_cfg_ff[`LINK_SYNC_SEL] ? ts_sync_ff[1] : se_sync_ff[1];
  assign mode_8b10b   = is_8b10b(link_cfg_ff[`LINK_MODE_HI:0]);
  assign cal_finished = ctrl_ff[`CTRL_CAL_STAT_SEL] ? foreground_done_flag_ff : calibration_status_pin;

  always_comb begin
    nxt_link_state = link_state_ff;
    case (link_state_ff)
      conv_init_pkg::LINK_HALT: begin
        if (init_done_ff) nxt_link_state = mode_8b10b ? conv_init_pkg::LINK_WAIT_SYNC : conv_init_pkg::LINK_RUN;
      end
      conv_init_pkg::LINK_WAIT_SYNC: begin
        if (sync_ok) nxt_link_state = conv_init_pkg::LINK_RUN;
      end
      default: begin
        if (mode_8b10b && !sync_ok) nxt_link_state = conv_init_pkg::LINK_WAIT_SYNC;
      end
    endcase
    if (!ctrl_ff[`CTRL_LINK_EN]) nxt_link_state = conv_init_pkg::LINK_HALT;
    nxt_link_active = nxt_link_state == conv_init_pkg::LINK_RUN;
    nxt_data_valid  = nxt_link_active && align_sync_ff[1] && cal_finished;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      link_state_ff  <= conv_init_pkg::LINK_HALT;
      link_active_ff <= 1'b0;
      data_valid_ff  <= 1'b0;
    end else begin
      link_state_ff  <= nxt_link_state;
      link_active_ff <= nxt_link_active;
      data_valid_ff  <= nxt_data_valid;
    end
  end

  assign rd_data                = rd_data_ff;
  assign irq                    = irq_ff;
  assign calibration_status_pin = foreground_done_flag_ff;
  assign link_active            = link_active_ff;
  assign data_valid             = data_valid_ff;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  // The age of a calibration run is counted apart from the calibration counter, so a stuck
  // counter in the run cannot also hide its own overrun.
  logic [11:0] fg_age_ff, nxt_fg_age;

  always_comb begin
    nxt_fg_age = 12'h000;
    if (cal_state_ff == conv_init_pkg::CAL_RUN) nxt_fg_age = fg_age_ff + 12'h001;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fg_age_ff <= 12'h000;
    end else begin
      fg_age_ff <= nxt_fg_age;
    end
  end

  property p_init_done;
    @(posedge ref_clk) disable iff (!rst_n) ctrl_ff[`CTRL_SOFT_RESET] |-> ##[INIT_CYC:INIT_MAX] init_done_ff;
  endproperty
  a_init_done: assert property (p_init_done) else $error("init done not set after soft reset");
  property p_init_wait;
    @(posedge ref_clk) disable iff (!rst_n) ctrl_ff[`CTRL_SOFT_RESET] |=> !init_done_ff [*8];
  endproperty
  a_init_wait: assert property (p_init_wait) else $error("init done set too early");
  property p_manual_trim;
    @(posedge ref_clk) disable iff (!rst_n)
      pll_state_ff == conv_init_pkg::PLL_HELD && pll_rst_prev_ff && !ctrl_ff[`CTRL_PLL_RESET] && init_done_ff &&
      !ctrl_ff[`CTRL_OSC_CAL_EN] && strap_sync_ff[1] && !ctrl_ff[`CTRL_SOFT_RESET] |=> osc_cal_done_ff;
  endproperty
  a_manual_trim: assert property (p_manual_trim) else $error("manual trim did not skip calibration");
  property p_lock_needs_release;
    @(posedge ref_clk) disable iff (!rst_n) pll_locked_ff |-> osc_cal_done_ff && !$past(ctrl_ff[`CTRL_PLL_RESET]);
  endproperty
  a_lock_needs_release: assert property (p_lock_needs_release) else $error("lock while PLL reset");
  property p_link_halt;
    @(posedge ref_clk) disable iff (!rst_n)
      !ctrl_ff[`CTRL_LINK_EN] |=> link_state_ff == conv_init_pkg::LINK_HALT && !link_active_ff;
  endproperty
  a_link_halt: assert property (p_link_halt) else $error("link not halted");
  property p_link_cfg_frozen;
    @(posedge ref_clk) disable iff (!rst_n) ctrl_ff[`CTRL_LINK_EN] |=> $stable(link_cfg_ff);
  endproperty
  a_link_cfg_frozen: assert property (p_link_cfg_frozen) else $error("link settings changed while enabled");
  property p_cal_halt;
    @(posedge ref_clk) disable iff (!rst_n)
      !ctrl_ff[`CTRL_CAL_EN] |=> cal_state_ff == conv_init_pkg::CAL_IDLE && !calibration_status_pin;
  endproperty
  a_cal_halt: assert property (p_cal_halt) else $error("calibration not halted");
  property p_cal_cfg_frozen;
    @(posedge ref_clk) disable iff (!rst_n) ctrl_ff[`CTRL_CAL_EN] |=> $stable(cal_cfg_ff);
  endproperty
  a_cal_cfg_frozen: assert property (p_cal_cfg_frozen) else $error("cal settings changed while enabled");
  property p_link_restart;
    @(posedge ref_clk) disable iff (!rst_n)
      ctrl_ff[`CTRL_LINK_EN] && init_done_ff && link_state_ff == conv_init_pkg::LINK_HALT |=>
      link_state_ff != conv_init_pkg::LINK_HALT;
  endproperty
  a_link_restart: assert property (p_link_restart) else $error("link did not restart");
  property p_fg_time;
    @(posedge ref_clk) disable iff (!rst_n)
      cal_state_ff == conv_init_pkg::CAL_RUN |-> fg_age_ff < 12'(FG_CYC);
  endproperty
  a_fg_time: assert property (p_fg_time) else $error("foreground calibration overran");
  property p_foreground_done_flag_pin;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(foreground_done_flag_ff) |-> calibration_status_pin && $past(cal_state_ff) == conv_init_pkg::CAL_RUN;
  endproperty
  a_foreground_done_flag_pin: assert property (p_foreground_done_flag_pin) else $error("done flag without calibration run");
  property p_sync_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      link_state_ff == conv_init_pkg::LINK_WAIT_SYNC && !sync_ok |=> !link_active_ff;
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("link ran without sync");
  property p_no_sync_64b;
    @(posedge ref_clk) disable iff (!rst_n)
      link_state_ff == conv_init_pkg::LINK_RUN && ctrl_ff[`CTRL_LINK_EN] && !mode_8b10b |=> link_active_ff;
  endproperty
  a_no_sync_64b: assert property (p_no_sync_64b) else $error("64B/66B link reacted to sync");
  property p_valid;
    @(posedge ref_clk) disable iff (!rst_n) data_valid_ff |-> link_active_ff && $past(align_sync_ff[1]);
  endproperty
  a_valid: assert property (p_valid) else $error("data valid without link and alignment");
  c_foreground_done_flag: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(foreground_done_flag_ff));
  c_locked: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(pll_locked_ff));
  c_valid: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(data_valid_ff) && mode_8b10b);
endmodule

// ===== sim/rx_model.sv
// Receiver model at the far end of the converter link.
// Assumes ref_clk is the converter clock; alignment follows link_active after four edges,
// and sync is requested (held low) for the first 256 cycles of the run.
module rx_model (
  input  wire logic ref_clk,
  input  wire logic link_active,
  output logic      rx_aligned,
  output logic      sync_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] dly_ff = 4'h0;
  logic [8:0] age_ff = 9'h000;
  // Alignment is lost as soon as the link halts, as a real receiver would.
  // The late sync makes an 8B/10B link wait first, so the sync gate is really exercised.
  always @(posedge ref_clk) begin
    dly_ff <= link_active ? {dly_ff[2:0], 1'b1} : 4'h0;
    if (!age_ff[8]) age_ff <= age_ff + 9'h001;
  end
  assign rx_aligned = dly_ff[3];
  assign sync_ok    = age_ff[8];
endmodule

// ===== sim/testbench.sv
// Self-checking bench of the converter startup block.
// Assumes the register map of conv_init_defs.svh and a 100 MHz clock.
`include "conv_init_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wr_data = 32'h0000_0000;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic        trig    = 1'b0;
  logic [31:0] rd_data;
  logic        rx_al, sync_ok, cal_stat, link_act, dvalid, irq;
  int          error_cnt = 0;
  int          samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  converter_startup_init_sequence dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pll_enable_strap(1'b1),
    .single_ended_sync_input(sync_ok), .timestamp_diff_input(sync_ok), .calibration_trigger_pin(trig),
    .rx_aligned(rx_al),
    .calibration_status_pin(cal_stat), .link_active(link_act), .data_valid(dvalid), .irq(irq));
  rx_model rx (.ref_clk(ref_clk), .link_active(link_act), .rx_aligned(rx_al), .sync_ok(sync_ok));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a; wr_data <= d; wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk(what, exp, rd_data & m);
  endtask
  task automatic wait_hi(ref logic s, input int n);
    for (int i = 0; i < n && s !== 1'b1; i++) @(posedge ref_clk);
    #1;
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_init;
    rd(`ADDR_CTRL, 32'hffff_ffff, `CTRL_RESET, "ctrl reset");
    rd(`ADDR_STATUS, 32'h1, 32'h0, "init early");
    repeat (200) @(posedge ref_clk);
    rd(`ADDR_STATUS, 32'h1, 32'h1, "init done");
    chk("link waits for sync", 0, link_act);
    wr(`ADDR_CTRL, 32'h0000_000d);
    rd(`ADDR_STATUS, 32'h1, 32'h0, "init after soft reset");
    wait_hi(link_act, 100);
    chk("link after sync", 1, link_act);
    repeat (200) @(posedge ref_clk);
    rd(`ADDR_STATUS, 32'h1, 32'h1, "init done again");
    rd(8'h40, 32'hffff_ffff, 32'h0, "unmapped");
    $display("init test done");
  endtask
  task automatic t_pll;
    wr(`ADDR_CTRL, 32'h0000_0102);
    wr(`ADDR_PLL_CFG, 32'h0052_204a);
    wr(`ADDR_CTRL, 32'h0000_0100);
    rd(`ADDR_STATUS, 32'h6, 32'h0, "osc cal early");
    repeat (640) @(posedge ref_clk);
    rd(`ADDR_STATUS, 32'h6, 32'h6, "osc done and locked");
    wr(`ADDR_CTRL, 32'h0000_0002);
    wr(`ADDR_TRIM, 32'h0000_005a);
    rd(`ADDR_TRIM, 32'hffff_ffff, 32'h0000_005a, "manual trim");
    wr(`ADDR_CTRL, 32'h0000_0000);
    rd(`ADDR_STATUS, 32'h6, 32'h2, "trim skips osc cal");
    repeat (100) @(posedge ref_clk);
    rd(`ADDR_STATUS, 32'h6, 32'h6, "locked after trim");
    wr(`ADDR_LINK_CFG, 32'h8101_0108);
    rd(`ADDR_LINK_CFG, 32'hffff_ffff, 32'h8101_0108, "link cfg halted");
    wr(`ADDR_CAL_CFG, 32'h0000_0002);
    rd(`ADDR_CAL_CFG, 32'h3, 32'h2, "cal cfg halted");
    $display("pll test done");
  endtask
  task automatic t_cal;
    wr(`ADDR_IRQ_MASK, 32'h0000_0004);
    wr(`ADDR_CTRL, 32'h0000_011c);
    wait_hi(link_act, 10);
    chk("link active", 1, link_act);
    wr(`ADDR_LINK_CFG, 32'h0000_0003);
    rd(`ADDR_LINK_CFG, 32'hffff_ffff, 32'h8101_0108, "link cfg locked");
    chk("valid before cal", 0, dvalid);
    wr(`ADDR_CTRL, 32'h0000_013c);
    wait_hi(cal_stat, 2100);
    chk("status pin", 1, cal_stat);
    repeat (3) @(posedge ref_clk);
    chk("data valid", 1, dvalid);
    chk("irq", 1, irq);
    rd(`ADDR_IRQ_STAT, 32'hf, 32'hf, "irq status");
    #1 chk("irq cleared", 0, irq);
    wr(`ADDR_CTRL, 32'h0000_017c);
    trig <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("pin trigger clears", 0, cal_stat);
    wait_hi(cal_stat, 2100);
    rd(`ADDR_STATUS, 32'h8, 32'h8, "foreground_done_flag pin");
    $display("cal test done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_init();
    t_pll();
    t_cal();
    results();
  end
  initial begin
    #200us;
    error_cnt++;
    results();
  end
endmodule
